// ===== design/lin_position_command_decoder.sv
// Decoder of LIN absolute and compact move frames for a positioner node.
// Assumes a LIN byte engine delivers frame bytes synchronous to SYS_CLK_I.
//
// Contract
// - Direct frame: two bytes, high then low
// - Identifier: parity on top, bit5 zero
// - General frame: command, address, position bytes
// - General broadcast clear: every node adopts position
// - Diagnostic 0x3C frame carries two motor slots
// - Full-range positions are signed 16-bit
// - Compact moves only in half stepping
// - Compact address is four OTP bits
// - One-motor compact byte layout
// - Compact broadcast clear: every node adopts position
// - Two-motor compact frame with two slots
// - Compact slots compare low four address bits
// - Compact positions are signed 11-bit
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module lin_position_command_decoder
	import lin_move_pkg::*;
(
	input  wire logic        SYS_CLK_I,
	input  wire logic        ARST_N_I,
	input  wire logic        FRAME_START_I,
	input  wire logic        BYTE_VALID_I,
	input  wire logic [7:0]  BYTE_I,
	input  wire logic        FRAME_END_I,
	input  wire logic [3:0]  OTP_NODE_ADDRESS_BITS_I,
	input  wire logic        HARDWIRED_ADDRESS_BIT_A_I,
	input  wire logic        HARDWIRED_ADDRESS_BIT_B_I,
	input  wire logic        HARDWIRED_ADDRESS_BIT_C_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic      [15:0] TARGET_POSITION_O,
	output logic             TARGET_UPDATE_O,
	output logic             FRAME_REJECT_O
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// Frame capture
	// ------------------------------------------------------------
	frame_if frm();

	lin_frame_capture u_capture (
		.clk_i         (SYS_CLK_I),
		.rst_n_i       (rst_n),
		.frame_start_i (FRAME_START_I),
		.byte_valid_i  (BYTE_VALID_I),
		.byte_i        (BYTE_I),
		.frame_end_i   (FRAME_END_I),
		.frm           (frm.capture)
	);

	// ------------------------------------------------------------
	// Configuration held by software
	// ------------------------------------------------------------
	logic [1:0] step_resolution_select;
	logic       decode_enable;
	logic [5:0] direct_move_fid;
	logic [5:0] general_move_fid;
	logic [5:0] compact_one_fid;
	logic [5:0] compact_two_fid;

	// ------------------------------------------------------------
	// Frame classification
	// ------------------------------------------------------------
	wire logic [5:0] frame_identifier_field = frm.pid[5:0];
	wire logic [6:0] own_address = {HARDWIRED_ADDRESS_BIT_C_I,
	                                 HARDWIRED_ADDRESS_BIT_B_I,
	                                 HARDWIRED_ADDRESS_BIT_A_I,
	                                 OTP_NODE_ADDRESS_BITS_I};
	wire logic [3:0] otp_node_address_bits = OTP_NODE_ADDRESS_BITS_I;

	wire logic [7:0] d1 = frm.data[0];
	wire logic [7:0] d2 = frm.data[1];
	wire logic [7:0] d3 = frm.data[2];
	wire logic [7:0] d4 = frm.data[3];
	wire logic [7:0] d5 = frm.data[4];
	wire logic [7:0] d6 = frm.data[5];
	wire logic [7:0] d7 = frm.data[6];
	wire logic [7:0] d8 = frm.data[7];

	wire logic pid_ok     = pid_parity_ok(frm.pid);
	wire logic frame_good = frm.done && frm.ok && pid_ok && decode_enable;
	wire logic frame_bad  = frm.done && !(frm.ok && pid_ok);
	wire logic half_step  = step_resolution_select == HALF_STEP;

	// Direct frames need identifier bit 5 clear
	wire logic is_direct = (frame_identifier_field == direct_move_fid)
	                    && !frame_identifier_field[5]
	                    && (frm.len == LEN_TWO);

	wire logic is_general = (frame_identifier_field == general_move_fid)
	                     && (frm.len == LEN_FOUR)
	                     && (d1 == MOVE_CMD_BYTE);

	wire logic is_diag = (frame_identifier_field == DIAG_FRAME_ID)
	                  && (frm.len == LEN_EIGHT)
	                  && (d1 == APPLICATION_COMMAND_MARKER)
	                  && (d2 == MOVE_CMD_BYTE);

	// Compact forms are dropped outside half stepping
	wire logic is_compact_one = half_step
	                         && (frame_identifier_field == compact_one_fid)
	                         && !frame_identifier_field[5]
	                         && (frm.len == LEN_TWO);

	wire logic is_compact_two = half_step
	                         && (frame_identifier_field == compact_two_fid)
	                         && (frame_identifier_field[5:4] == GP_ID_TOP)
	                         && (frm.len == LEN_FOUR);

	// ------------------------------------------------------------
	// Address slots
	// ------------------------------------------------------------
	logic hit_general;
	logic hit_diag_one;
	logic hit_diag_two;
	logic hit_compact;
	logic hit_pair_one;
	logic hit_pair_two;

	address_slot_match #(.AW(7), .OPEN_ON_CLEAR(1'b1)) u_slot_general (
		.tag_i   (d2[7]),
		.field_i (d2[6:0]),
		.own_i   (own_address),
		.hit_o   (hit_general)
	);

	// Diagnostic slots carry a fixed one in bit 7; a zero there selects nobody
	address_slot_match #(.AW(7), .OPEN_ON_CLEAR(1'b0)) u_slot_diag_one (
		.tag_i   (d3[7]),
		.field_i (d3[6:0]),
		.own_i   (own_address),
		.hit_o   (hit_diag_one)
	);

	address_slot_match #(.AW(7), .OPEN_ON_CLEAR(1'b0)) u_slot_diag_two (
		.tag_i   (d6[7]),
		.field_i (d6[6:0]),
		.own_i   (own_address),
		.hit_o   (hit_diag_two)
	);

	address_slot_match #(.AW(4), .OPEN_ON_CLEAR(1'b1)) u_slot_compact (
		.tag_i   (d1[4]),
		.field_i (d1[3:0]),
		.own_i   (otp_node_address_bits),
		.hit_o   (hit_compact)
	);

	address_slot_match #(.AW(4), .OPEN_ON_CLEAR(1'b0)) u_slot_pair_one (
		.tag_i   (d1[4]),
		.field_i (d1[3:0]),
		.own_i   (otp_node_address_bits),
		.hit_o   (hit_pair_one)
	);

	address_slot_match #(.AW(4), .OPEN_ON_CLEAR(1'b0)) u_slot_pair_two (
		.tag_i   (d3[4]),
		.field_i (d3[3:0]),
		.own_i   (otp_node_address_bits),
		.hit_o   (hit_pair_two)
	);

	// ------------------------------------------------------------
	// Position selection
	// ------------------------------------------------------------
	wire logic accept_full = is_direct
	                      || (is_general && hit_general)
	                      || (is_diag && (hit_diag_one || hit_diag_two));

	wire logic accept_compact = (is_compact_one && hit_compact)
	                         || (is_compact_two && (hit_pair_one || hit_pair_two));

	wire logic accept = frame_good && (accept_full || accept_compact);

	// Full-range set-points pass as signed 16-bit words
	wire logic [15:0] pos_direct  = {d1, d2};
	wire logic [15:0] pos_general = {d3, d4};
	wire logic [15:0] pos_diag    = hit_diag_one ? {d4, d5} : {d7, d8};

	// Compact set-points are sign-extended from bit 10
	wire logic [15:0] pos_compact_one = {{5{d1[7]}}, d1[7:5], d2};
	wire logic [15:0] pos_pair_one    = {{5{d1[7]}}, d1[7:5], d2};
	wire logic [15:0] pos_pair_two    = {{5{d3[7]}}, d3[7:5], d4};

	// First matching slot wins when a frame names the node twice
	wire logic [15:0] next_position =
		is_direct                    ? pos_direct :
		(is_general && hit_general)  ? pos_general :
		(is_diag)                    ? pos_diag :
		is_compact_one               ? pos_compact_one :
		hit_pair_one                 ? pos_pair_one :
		                               pos_pair_two;

	// ------------------------------------------------------------
	// Target and counters
	// ------------------------------------------------------------
	logic       compact_last;
	logic       target_seen;
	logic [7:0] accept_count;
	logic [7:0] reject_count;

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			TARGET_POSITION_O <= 16'h0000;
			TARGET_UPDATE_O   <= 1'b0;
			FRAME_REJECT_O    <= 1'b0;
			compact_last      <= 1'b0;
			target_seen       <= 1'b0;
		end else begin
			TARGET_UPDATE_O <= accept;
			FRAME_REJECT_O  <= frame_bad;
			if (accept) begin
				TARGET_POSITION_O <= next_position;
				compact_last      <= !accept_full;
				target_seen       <= 1'b1;
			end
		end
	end

	// Counters wrap; software reads them as differences
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			accept_count <= 8'h00;
			reject_count <= 8'h00;
		end else begin
			accept_count <= accept_count + {7'h00, accept};
			reject_count <= reject_count + {7'h00, frame_bad};
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	wire logic setup_phase = PSEL_I && !PENABLE_I;
	wire logic write_now   = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
	wire logic sel_ctrl    = PADDR_I == REG_CTRL;
	wire logic sel_idcfg   = PADDR_I == REG_IDCFG;
	wire logic sel_target  = PADDR_I == REG_TARGET;
	wire logic sel_status  = PADDR_I == REG_STATUS;
	wire logic mapped      = sel_ctrl || sel_idcfg || sel_target || sel_status;

	wire logic [31:0] ctrl_word  = {23'h000000, decode_enable, 6'h00, step_resolution_select};
	wire logic [31:0] idcfg_word = {2'h0, compact_two_fid, 2'h0, compact_one_fid,
	                                2'h0, general_move_fid, 2'h0, direct_move_fid};
	wire logic [31:0] targ_word  = {14'h0000, compact_last, target_seen, TARGET_POSITION_O};
	wire logic [31:0] stat_word  = {16'h0000, reject_count, accept_count};

	wire logic [31:0] read_mux = sel_ctrl   ? ctrl_word :
	                             sel_idcfg  ? idcfg_word :
	                             sel_target ? targ_word :
	                             sel_status ? stat_word : 32'h0000_0000;

	// Zero-wait answer: ready and data are set up during the setup cycle
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
		end else begin
			PREADY_O  <= setup_phase;
			PSLVERR_O <= setup_phase && !mapped;
			if (setup_phase) begin
				PRDATA_O <= PWRITE_I ? 32'h0000_0000 : read_mux;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			step_resolution_select <= STEP_RESET;
			decode_enable          <= EN_RESET;
		end else if (write_now && sel_ctrl) begin
			step_resolution_select <= PWDATA_I[CTRL_STEP_LSB +: 2];
			decode_enable          <= PWDATA_I[CTRL_EN_BIT];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			direct_move_fid  <= IDCFG_RESET[IDCFG_DIR_LSB +: 6];
			general_move_fid <= IDCFG_RESET[IDCFG_GP_LSB +: 6];
			compact_one_fid  <= IDCFG_RESET[IDCFG_C1_LSB +: 6];
			compact_two_fid  <= IDCFG_RESET[IDCFG_C2_LSB +: 6];
		end else if (write_now && sel_idcfg) begin
			direct_move_fid  <= PWDATA_I[IDCFG_DIR_LSB +: 6];
			general_move_fid <= PWDATA_I[IDCFG_GP_LSB +: 6];
			compact_one_fid  <= PWDATA_I[IDCFG_C1_LSB +: 6];
			compact_two_fid  <= PWDATA_I[IDCFG_C2_LSB +: 6];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_direct_bytes: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(frame_good && is_direct) |=> (TARGET_UPDATE_O && TARGET_POSITION_O == {$past(d1), $past(d2)}))
		else $error("direct move position not taken high byte first");

	a_pid_reject: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(frm.done && !pid_parity_ok(frm.pid)) |=> !TARGET_UPDATE_O)
		else $error("frame with bad identifier parity updated target");

	a_general_fields: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(frame_good && is_general && hit_general && !is_direct)
		|=> (TARGET_POSITION_O == {$past(d3), $past(d4)}))
		else $error("general move position taken from wrong bytes");

	a_general_bcast: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(frame_good && is_general && !d2[7]) |=> TARGET_UPDATE_O)
		else $error("general broadcast move not adopted");

	a_diag_slot: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(frame_good && is_diag && hit_diag_one && !is_direct && !is_general)
		|=> (TARGET_POSITION_O == {$past(d4), $past(d5)}))
		else $error("first diagnostic slot position wrong");

	a_step_gate: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(frame_good && !half_step && !accept_full) |=> !TARGET_UPDATE_O)
		else $error("compact move acted on outside half stepping");

	a_compact_one: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(frame_good && is_compact_one && hit_compact && !accept_full)
		|=> ((TARGET_POSITION_O[7:0] == $past(d2))
		    && ({TARGET_POSITION_O[10:8], 5'h00} == ($past(d1) & 8'he0))))
		else $error("one-motor compact position wrong");

	a_compact_sign: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(TARGET_UPDATE_O && compact_last) |-> (TARGET_POSITION_O[15:11] == {5{TARGET_POSITION_O[10]}}))
		else $error("compact position not sign-extended");

	a_bad_hold: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(frm.done && !frm.ok) |=> (!TARGET_UPDATE_O && $stable(TARGET_POSITION_O) && FRAME_REJECT_O))
		else $error("bad checksum frame changed target");

endmodule

// ===== design/lin_move_pkg.sv
// Constants, register map and helper functions of the position decoder.
// Assumes frames reach the block as whole bytes from a LIN byte engine.
package lin_move_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_IDCFG     = 8'h04;
	localparam logic [7:0]  REG_TARGET    = 8'h08;
	localparam logic [7:0]  REG_STATUS    = 8'h0c;
	localparam int          CTRL_STEP_LSB = 0;
	localparam int          CTRL_EN_BIT   = 8;
	localparam int          IDCFG_DIR_LSB = 0;
	localparam int          IDCFG_GP_LSB  = 8;
	localparam int          IDCFG_C1_LSB  = 16;
	localparam int          IDCFG_C2_LSB  = 24;
	localparam logic [1:0]  STEP_RESET    = 2'h0;
	localparam logic        EN_RESET      = 1'b1;
	localparam logic [31:0] IDCFG_RESET   = 32'h2102_2001;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam logic [5:0] DIAG_FRAME_ID              = 6'h3c;
	localparam logic [5:0] CLASSIC_CS_FROM            = 6'h3c;
	localparam logic [7:0] APPLICATION_COMMAND_MARKER = 8'h80;
	localparam logic [7:0] MOVE_CMD_BYTE              = 8'h8b;
	localparam logic [1:0] HALF_STEP                  = 2'h0;
	localparam logic [1:0] GP_ID_TOP                  = 2'h2;
	localparam logic [3:0] LEN_TWO                    = 4'h2;
	localparam logic [3:0] LEN_FOUR                   = 4'h4;
	localparam logic [3:0] LEN_EIGHT                  = 4'h8;
	localparam logic [7:0] CS_GOOD                    = 8'hff;
	localparam int         MAX_DATA                   = 8;

	// Sum with end-around carry, as the LIN checksum needs
	function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

	function automatic logic pid_parity_ok(input logic [7:0] p);
		logic p0;
		logic p1;
		p0 = p[0] ^ p[1] ^ p[2] ^ p[4];
		p1 = ~(p[1] ^ p[3] ^ p[4] ^ p[5]);
		return (p[6] == p0) && (p[7] == p1);
	endfunction

endpackage

// ===== design/frame_if.sv
// Carrier of one captured LIN frame from the byte collector to the decoder.
// Assumes one driver (capture) and one reader (decode).
`timescale 1ns/1ps
interface frame_if;
	logic       done;
	logic       ok;
	logic [7:0] pid;
	logic [3:0] len;
	logic [7:0] data [0:7];
	modport capture (output done, output ok, output pid, output len, output data);
	modport decode  (input done, input ok, input pid, input len, input data);
endinterface

// ===== design/lin_frame_capture.sv
// Collects the bytes of one LIN frame and checks its trailing checksum.
// Assumes frame_end_i comes in a cycle after the checksum byte.
`timescale 1ns/1ps
module lin_frame_capture
	import lin_move_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       frame_start_i,
	input  wire logic       byte_valid_i,
	input  wire logic [7:0] byte_i,
	input  wire logic       frame_end_i,
	frame_if.capture        frm
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PID  = 3'b010,
		ST_DATA = 3'b100
	} cap_state_t;

	cap_state_t state;
	logic [3:0] cnt;
	logic [7:0] sum_cls;
	logic [7:0] sum_enh;

	// Identifiers 0x3C and up use the classic sum, all others include the identifier
	wire logic       classic  = frm.pid[5:0] >= CLASSIC_CS_FROM;
	wire logic [7:0] sum_pick = classic ? sum_cls : sum_enh;
	wire logic       len_ok   = (cnt >= 4'h2) && (cnt <= 4'h9);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state   <= ST_IDLE;
			cnt     <= 4'h0;
			sum_cls <= 8'h00;
			sum_enh <= 8'h00;
			frm.pid <= 8'h00;
			frm.len <= 4'h0;
			frm.ok  <= 1'b0;
			frm.done <= 1'b0;
			for (int i = 0; i < MAX_DATA; i++) begin
				frm.data[i] <= 8'h00;
			end
		end else begin
			frm.done <= 1'b0;
			if (frame_start_i) begin
				state <= ST_PID;
				cnt   <= 4'h0;
			end else unique case (state)
				ST_IDLE: ;
				ST_PID: begin
					if (byte_valid_i) begin
						frm.pid <= byte_i;
						sum_enh <= byte_i;
						sum_cls <= 8'h00;
						state   <= ST_DATA;
					end
					if (frame_end_i) state <= ST_IDLE;
				end
				ST_DATA: begin
					if (byte_valid_i && cnt != 4'ha) begin
						if (cnt < 4'h8) frm.data[cnt[2:0]] <= byte_i;
						sum_cls <= add_carry(sum_cls, byte_i);
						sum_enh <= add_carry(sum_enh, byte_i);
						cnt     <= cnt + 4'h1;
					end
					if (frame_end_i) begin
						frm.done <= 1'b1;
						frm.ok   <= len_ok && (sum_pick == CS_GOOD);
						frm.len  <= cnt - 4'h1;
						state    <= ST_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// ===== design/address_slot_match.sv
// Decides whether one address slot of a move frame selects this node.
// Assumes the own address is already cut to the slot's field width.
`timescale 1ns/1ps
module address_slot_match #(
	parameter int   AW            = 7,
	parameter logic OPEN_ON_CLEAR = 1'b1
) (
	input  wire logic          tag_i,
	input  wire logic [AW-1:0] field_i,
	input  wire logic [AW-1:0] own_i,
	output wire logic          hit_o
);
	if (AW < 1 || AW > 7) begin : g_bad_width
		$error("address_slot_match: AW must be 1 to 7");
	end

	// Tag clear opens the slot to every node where the format allows it
	assign hit_o = tag_i ? (field_i == own_i) : OPEN_ON_CLEAR;
endmodule

// ===== sim/lin_master_model.sv
// Model of the LIN bus master: sends one write frame as a byte stream.
// Assumes the node samples every strobe at the rising edge of clk_i.
`timescale 1ns/1ps
module lin_master_model (
	input  wire logic       clk_i,
	output logic            frame_start_o,
	output logic            byte_valid_o,
	output logic [7:0]      byte_o,
	output logic            frame_end_o
);
	initial begin
		frame_start_o = 1'b0;
		byte_valid_o  = 1'b0;
		byte_o        = 8'h00;
		frame_end_o   = 1'b0;
	end

	function automatic logic [7:0] wrap_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

	// Data bytes are left aligned in d, first byte in d[63:56]
	// Bad bit 0 spoils the checksum, bit 1 the identifier parity
	task automatic send(input logic [5:0] id, input logic [63:0] d, input int n, input logic [1:0] bad);
		logic [7:0] pid;
		logic [7:0] sum;
		pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]) ^ bad[1], id[0] ^ id[1] ^ id[2] ^ id[4], id};
		sum = (id >= 6'h3c) ? 8'h00 : pid;
		@(posedge clk_i);
		frame_start_o <= 1'b1;
		@(posedge clk_i);
		frame_start_o <= 1'b0;
		byte_valid_o  <= 1'b1;
		byte_o        <= pid;
		for (int k = 0; k < n; k++) begin
			@(posedge clk_i);
			byte_o <= d[63-8*k -: 8];
			sum = wrap_add(sum, d[63-8*k -: 8]);
		end
		@(posedge clk_i);
		byte_o <= bad[0] ? (~sum ^ 8'h01) : ~sum;
		@(posedge clk_i);
		// Idle data line shows the inverse, never a stale byte
		byte_valid_o <= 1'b0;
		byte_o       <= ~byte_o;
		frame_end_o  <= 1'b1;
		@(posedge clk_i);
		frame_end_o <= 1'b0;
	endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench of the position decoder, APB registers and frames.
// Assumes zero-wait APB and results two cycles after the frame end.
`timescale 1ns/1ps
module tb_top;
	import lin_move_pkg::*;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic        err;
	logic [3:0]  otp = 4'h0;
	logic [6:0]  own;
	logic        fs, bv, fe;
	logic [7:0]  bt;
	logic [31:0] prdata;
	logic        pready, pslverr, upd, rej;
	logic [15:0] tpos, exp_pos, p1, p2;
	int          err_count = 0, checks_done = 0, cycles = 0;

	always #10 clk = ~clk;
	// Hardwired bits not all high, so compact frames must use only four bits
	assign own = {3'b101, otp};

	lin_master_model i_lin_master_model (.clk_i(clk), .frame_start_o(fs), .byte_valid_o(bv),
		.byte_o(bt), .frame_end_o(fe));
	lin_position_command_decoder i_lin_position_command_decoder (.SYS_CLK_I(clk), .ARST_N_I(arst_n),
		.FRAME_START_I(fs), .BYTE_VALID_I(bv), .BYTE_I(bt), .FRAME_END_I(fe),
		.OTP_NODE_ADDRESS_BITS_I(otp), .HARDWIRED_ADDRESS_BIT_A_I(1'b1), .HARDWIRED_ADDRESS_BIT_B_I(1'b0),
		.HARDWIRED_ADDRESS_BIT_C_I(1'b1), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.TARGET_POSITION_O(tpos), .TARGET_UPDATE_O(upd), .FRAME_REJECT_O(rej));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for ready
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [15:0] sx11(input logic [10:0] p);
		return {{5{p[10]}}, p};
	endfunction

	// Sends a frame and compares update, reject and target
	task automatic frame(input logic [5:0] id, input logic [63:0] d, input int n, input logic [1:0] bad,
			input logic eu, input logic [15:0] ep);
		logic su, sr;
		su = 1'b0;
		sr = 1'b0;
		i_lin_master_model.send(id, d, n, bad);
		repeat (6) begin
			@(posedge clk);
			#1;
			su = su | (upd === 1'b1);
			sr = sr | (rej === 1'b1);
		end
		check(su, eu);
		check(sr, {31'h0, |bad});
		check(tpos, ep);
		exp_pos = ep;
		$display("frame test id %h done", id);
	endtask

	initial begin
		void'($urandom(32'h9d1ed2a0));
		otp <= 4'($urandom);
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, REG_CTRL, 32'h0);
		check(rd, 32'h0000_0100);
		apb(1'b0, REG_IDCFG, 32'h0);
		check(rd, IDCFG_RESET);
		apb(1'b1, 8'h14, 32'hffff_ffff);
		check(rd, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("register test done");
		p1 = 16'($urandom);
		frame(6'h01, {p1, 48'h0}, 2, 2'b00, 1'b1, p1);
		frame(6'h01, {~p1, 48'h0}, 2, 2'b01, 1'b0, p1);
		frame(6'h01, {~p1, 48'h0}, 2, 2'b10, 1'b0, p1);
		p2 = 16'($urandom);
		frame(6'h20, {8'h8b, 1'b0, ~own, p2, 32'h0}, 4, 2'b00, 1'b1, p2);
		frame(6'h20, {8'h8b, 1'b1, own ^ 7'h40, p1, 32'h0}, 4, 2'b00, 1'b0, p2);
		frame(6'h20, {8'h8b, 1'b1, own, p1, 32'h0}, 4, 2'b00, 1'b1, p1);
		p1 = 16'($urandom);
		p2 = 16'($urandom);
		frame(6'h3c, {8'h80, 8'h8b, 1'b1, own ^ 7'h01, p1, 1'b1, own, p2}, 8, 2'b00, 1'b1, p2);
		frame(6'h02, {p1[10:8], 1'b1, otp, p1[7:0], 48'h0}, 2, 2'b00, 1'b1,
			sx11(p1[10:0]));
		frame(6'h02, {p2[10:8], 1'b0, ~otp, p2[7:0], 48'h0}, 2, 2'b00, 1'b1, sx11(p2[10:0]));
		frame(6'h21, {p1[10:8], 1'b1, ~otp, p1[7:0], p2[2:0], 1'b1, otp, p2[15:8], 32'h0}, 4, 2'b00, 1'b1,
			sx11({p2[2:0], p2[15:8]}));
		apb(1'b1, REG_CTRL, 32'h0000_0101);
		frame(6'h02, {p1[10:8], 1'b0, otp, p1[7:0], 48'h0}, 2, 2'b00, 1'b0, exp_pos);
		// Decoding switched off: a good frame for this node must be ignored
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		frame(6'h01, {p2, 48'h0}, 2, 2'b00, 1'b0, exp_pos);
		apb(1'b1, REG_CTRL, 32'h0000_0100);
		apb(1'b0, REG_TARGET, 32'h0);
		check(rd, {14'h0, 1'b1, 1'b1, exp_pos});
		// Seven frames accepted, two refused for checksum and parity
		apb(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h0000_0207);
		$display("readback test done");
		end_of_test();
	end
endmodule
